// [src/lsi_interlock.sv]
`timescale 1ns/1ps
`include "lsi_defines.svh"

// Safety interlock: clocked hardware only, with each facility signal received as a
// complementary contact pair (one closed, one open).
module lsi_interlock (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Facility inputs, each a complementary pair
    input  wire logic estop1,
    input  wire logic estop1N,
    input  wire logic estop2,
    input  wire logic estop2N,
    input  wire logic shutPermit,
    input  wire logic shutPermitN,
    // Laser unit internal inputs
    input  wire logic laserRequest,
    input  wire logic lightSense,
    input  wire logic internalFault,
    input  wire logic shutClosedSense,
    input  wire logic shutOpenSense,
    input  wire logic faultClear,
    // Laser unit drives
    output logic      pumpEnable,
    output logic      shutterOpenCmd,
    output logic      powerKill,
    // Facility outputs
    output logic      emissionOn,
    output logic      safetyStatus,
    output logic      shutterClosed,
    output logic      shutterHealthy,
    output logic      hazardRadiation,
    output logic      systemFault,
    output logic      interfaceFault
);

    lsi_pkg::lsi_regs_t r_reg;
    lsi_pkg::lsi_regs_t r_next;

    localparam logic [7:0]  PairLimit = 8'(`LSI_PAIR_CYCLES);
    localparam logic [19:0] ShutLimit = 20'(`LSI_SHUT_CYCLES);

    logic pairBad;
    logic stop1;
    logic stop2;
    logic permit;
    logic shutBad;
    logic tripNow;
    logic liveCause;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Two halves of one contact pair reading alike cannot be a valid level.
    function automatic logic pairEqual(input logic [1:0] posSync,
                                       input logic [1:0] negSync);
        return posSync[1] == negSync[1];
    endfunction

    // The shutter counts as closed only with the closed sensor made and the open one not.
    function automatic logic sensedClosed(input logic [1:0] closedSync,
                                          input logic [1:0] openSync);
        return closedSync[1] & ~openSync[1];
    endfunction

    // ------------------------------------------------------------------
    // Decisions
    // ------------------------------------------------------------------
    always_comb begin
        // Pairs showing two equal halves are faulty.
        pairBad = pairEqual(r_reg.estop1Sync, r_reg.estop1nSync)
                | pairEqual(r_reg.estop2Sync, r_reg.estop2nSync)
                | pairEqual(r_reg.permitSync, r_reg.permitnSync);
        // Zero on level one asks for stop; a bad pair withdraws the shutter permit.
        stop1   = ~r_reg.estop1Sync[1];
        stop2   = r_reg.estop2Sync[1];
        permit  = r_reg.permitSync[1] & ~pairBad;
        // Shutter fault: both sensors agree and the shutter timer has reached its limit.
        shutBad = (r_reg.shutClosedSync[1] == r_reg.shutOpenSync[1])
                & (r_reg.shutCnt >= ShutLimit);
        tripNow = stop1 | stop2 | r_reg.ifaceFault | r_reg.shutFault
                | r_reg.intFaultSync[1];
        // Causes still present now; the latches are cleared by the same strobe
        // that leaves the trip, so one clear is enough once the causes are gone.
        liveCause = stop1 | stop2 | r_reg.intFaultSync[1] | shutBad
                  | (r_reg.pairCnt >= PairLimit);
    end

    always_comb begin
        r_next = r_reg;
        r_next.estop1Sync     = {r_reg.estop1Sync[0], estop1};
        r_next.estop1nSync    = {r_reg.estop1nSync[0], estop1N};
        r_next.estop2Sync     = {r_reg.estop2Sync[0], estop2};
        r_next.estop2nSync    = {r_reg.estop2nSync[0], estop2N};
        r_next.permitSync     = {r_reg.permitSync[0], shutPermit};
        r_next.permitnSync    = {r_reg.permitnSync[0], shutPermitN};
        r_next.shutClosedSync = {r_reg.shutClosedSync[0], shutClosedSense};
        r_next.shutOpenSync   = {r_reg.shutOpenSync[0], shutOpenSense};
        r_next.lightSync      = {r_reg.lightSync[0], lightSense};
        r_next.intFaultSync   = {r_reg.intFaultSync[0], internalFault};

        // A brief disagreement while contacts change over is tolerated.
        if (pairBad) begin
            if (r_reg.pairCnt < PairLimit) begin
                r_next.pairCnt = r_reg.pairCnt + 8'h01;
            end
        end else begin
            r_next.pairCnt = 8'h00;
        end

        // Shutter timer runs while the sensors do not show the commanded position.
        if ((r_reg.shutterOpenCmd ? r_reg.shutOpenSync[1] : r_reg.shutClosedSync[1])
                && (r_reg.shutClosedSync[1] != r_reg.shutOpenSync[1])) begin
            r_next.shutCnt = 20'h00000;
        end else if (r_reg.shutCnt < ShutLimit) begin
            r_next.shutCnt = r_reg.shutCnt + 20'h00001;
        end

        // Sticky faults; the set wins over a clear in the same cycle.
        if (faultClear) begin
            r_next.ifaceFault = 1'b0;
            r_next.shutFault  = 1'b0;
            r_next.sysFault   = 1'b0;
            r_next.powerKill  = 1'b0;
        end
        if (r_reg.pairCnt >= PairLimit) begin
            r_next.ifaceFault = 1'b1;
        end
        if (shutBad) begin
            r_next.shutFault = 1'b1;
        end
        if (r_reg.intFaultSync[1] | shutBad) begin
            r_next.sysFault = 1'b1;
        end
        if (stop2) begin
            r_next.powerKill = 1'b1;
        end

        case (r_reg.state)
            lsi_pkg::LSI_OFF: begin
                if (!tripNow) begin
                    r_next.state = lsi_pkg::LSI_READY;
                end
            end
            lsi_pkg::LSI_READY: begin
                if (tripNow) begin
                    r_next.state = lsi_pkg::LSI_TRIP;
                end else if (laserRequest) begin
                    r_next.state = lsi_pkg::LSI_EMIT;
                end
            end
            lsi_pkg::LSI_EMIT: begin
                if (tripNow) begin
                    r_next.state = lsi_pkg::LSI_TRIP;
                end else if (!laserRequest) begin
                    r_next.state = lsi_pkg::LSI_READY;
                end
            end
            lsi_pkg::LSI_TRIP: begin
                // Leaving the trip takes an explicit clear with every cause gone.
                if (faultClear && !liveCause) begin
                    r_next.state = lsi_pkg::LSI_READY;
                end
            end
            default: begin
                r_next.state = lsi_pkg::LSI_TRIP;
            end
        endcase

        r_next.pumpEnable     = (r_next.state == lsi_pkg::LSI_EMIT) & ~tripNow;
        r_next.shutterOpenCmd = r_next.pumpEnable & permit;
        r_next.emissionOn     = r_reg.lightSync[1];
        r_next.safetyOk       = ~(r_reg.sysFault | r_reg.intFaultSync[1]);
        r_next.shutterClosed  = sensedClosed(r_reg.shutClosedSync, r_reg.shutOpenSync);
        r_next.shutterOk      = ~r_reg.shutFault;
        // Light present and shutter not closed means radiation is exposed.
        r_next.hazard         = r_reg.lightSync[1]
                              & ~sensedClosed(r_reg.shutClosedSync, r_reg.shutOpenSync);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Reset leaves the unit dark, shutter commanded closed, faults clear.
            r_reg <= '{
                estop1Sync: 2'h0, estop1nSync: 2'h0, estop2Sync: 2'h0,
                estop2nSync: 2'h0, permitSync: 2'h0, permitnSync: 2'h0,
                shutClosedSync: 2'h0, shutOpenSync: 2'h0, lightSync: 2'h0,
                intFaultSync: 2'h0, pairCnt: 8'h00, shutCnt: 20'h00000,
                state: lsi_pkg::LSI_OFF, ifaceFault: 1'b0, shutFault: 1'b0,
                sysFault: 1'b0, powerKill: 1'b0, shutterOpenCmd: 1'b0,
                pumpEnable: 1'b0, emissionOn: 1'b0, safetyOk: 1'b0,
                shutterClosed: 1'b0, shutterOk: 1'b1, hazard: 1'b0
            };
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pumpEnable      = r_reg.pumpEnable;
    assign shutterOpenCmd  = r_reg.shutterOpenCmd;
    assign powerKill       = r_reg.powerKill;
    assign emissionOn      = r_reg.emissionOn;
    assign safetyStatus    = r_reg.safetyOk;
    assign shutterClosed   = r_reg.shutterClosed;
    assign shutterHealthy  = r_reg.shutterOk;
    assign hazardRadiation = r_reg.hazard;
    assign systemFault     = r_reg.sysFault;
    assign interfaceFault  = r_reg.ifaceFault;

endmodule // lsi_interlock

// [src/lsi_defines.svh]
`ifndef LSI_DEFINES_SVH
`define LSI_DEFINES_SVH
// Notes on behaviour
// - Safety logic is clocked hardware, no processor.
// - Each facility signal is a contact pair, closed means one.
// - Emission output one while light is produced.
// - Safety status zero while internal fault present.
// - Shutdown level one input zero stops light.
// - Shutdown level two input one removes power.
// - Shutter closed flag; open only with permissive.
// - Shutter fault output zero on shutter fault.
// - Hazard output one while radiation exposed.
// - System fault one on any internal fault.
// - Interface fault one when complementary pair equal.

// Cycles a pair may disagree with itself before it is called faulty (2 us at 40 MHz).
`define LSI_PAIR_TIME_NS      2000
`define LSI_CLK_PERIOD_NS     25
`define LSI_PAIR_CYCLES       (`LSI_PAIR_TIME_NS / `LSI_CLK_PERIOD_NS)
`define LSI_CNT_W             8
// Cycles allowed for the shutter to report its commanded position (10 ms).
`define LSI_SHUT_TIME_NS      10000000
`define LSI_SHUT_CYCLES       (`LSI_SHUT_TIME_NS / `LSI_CLK_PERIOD_NS)
`define LSI_SHUT_W            20
`endif

// [src/lsi_pkg.sv]
package lsi_pkg;
    typedef enum logic [1:0] {LSI_OFF, LSI_READY, LSI_EMIT, LSI_TRIP} lsi_state_t;

    typedef struct packed {
        logic [1:0]          estop1Sync;
        logic [1:0]          estop1nSync;
        logic [1:0]          estop2Sync;
        logic [1:0]          estop2nSync;
        logic [1:0]          permitSync;
        logic [1:0]          permitnSync;
        logic [1:0]          shutClosedSync;
        logic [1:0]          shutOpenSync;
        logic [1:0]          lightSync;
        logic [1:0]          intFaultSync;
        logic [7:0]          pairCnt;
        logic [19:0]         shutCnt;
        lsi_state_t          state;
        logic                ifaceFault;
        logic                shutFault;
        logic                sysFault;
        logic                powerKill;
        logic                shutterOpenCmd;
        logic                pumpEnable;
        logic                emissionOn;
        logic                safetyOk;
        logic                shutterClosed;
        logic                shutterOk;
        logic                hazard;
    } lsi_regs_t;
endpackage

// [bench/lsi_far_model.sv]
`timescale 1ns/1ps
// ----------------
// Facility and head
// ----------------
module lsi_far_model (
    input  wire logic sys_clk, stop1Req, stop2Req, permitReq, pairBreak,
    input  wire logic pumpEnable, shutterOpenCmd,
    output logic      estop1, estop1N, estop2, estop2N, shutPermit, shutPermitN,
    output logic      lightSense, shutClosedSense, shutOpenSense
);
    logic [3:0] cmdDly = 4'h0;
    logic       lightReg = 1'b0;
    // A closed contact reads one and its partner line is open; pairBreak inverts estop1N so both halves of the estop1 pair read alike.
    assign estop1      = !stop1Req;
    assign estop1N     = stop1Req ^ pairBreak;
    assign estop2      = stop2Req;
    assign estop2N     = !stop2Req;
    assign shutPermit  = permitReq;
    assign shutPermitN = !permitReq;
    // Both sensors read zero while the blade travels, so the design cannot rely on either.
    assign shutOpenSense   = &cmdDly;
    assign shutClosedSense = ~|cmdDly;
    assign lightSense      = lightReg;
    always_ff @(posedge sys_clk) begin
        cmdDly   <= {cmdDly[2:0], shutterOpenCmd};
        lightReg <= pumpEnable;
    end
endmodule // lsi_far_model

// [bench/lsi_interlock_asserts.sv]
`timescale 1ns/1ps
module lsi_interlock_chk (
    input wire logic sys_clk, rst, faultClear, lightSense, internalFault,
    input wire logic estop1, estop1N, estop2, estop2N, shutPermit, shutPermitN,
    input wire logic pumpEnable, shutterOpenCmd, powerKill, emissionOn, safetyStatus,
    input wire logic shutterClosed, hazardRadiation, systemFault, interfaceFault
);
    // ----------------
    // Checks
    // ----------------
    logic [7:0] eqCnt;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) eqCnt <= 8'h00;
        else if (estop1 != estop1N) eqCnt <= 8'h00;
        else if (eqCnt != 8'hff) eqCnt <= eqCnt + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    stop_pump_a: assert property ((!estop1 && estop1N)[*3] |=> !pumpEnable)
        else $error("pump on during stop");
    power_kill_a: assert property ((estop2 && !estop2N)[*3] |=> powerKill)
        else $error("power not removed");
    shut_permit_a: assert property ((!shutPermit && shutPermitN)[*3] |=> !shutterOpenCmd)
        else $error("shutter driven without permit");
    emit_on_a: assert property (lightSense[*5] |-> emissionOn)
        else $error("emission not shown");
    emit_off_a: assert property (!lightSense[*5] |-> !emissionOn)
        else $error("emission shown without light");
    safety_low_a: assert property (internalFault[*4] |=> !safetyStatus)
        else $error("safety status high in fault");
    sys_fault_a: assert property (internalFault[*4] |=> systemFault)
        else $error("system fault missing");
    fault_hold_a: assert property (systemFault && !faultClear |=> systemFault)
        else $error("system fault dropped without clear");
    iface_fault_a: assert property (eqCnt >= 8'h5a |-> interfaceFault)
        else $error("equal pair not flagged");
    hazard_show_a: assert property (hazardRadiation |-> emissionOn && !shutterClosed)
        else $error("hazard shown without exposure");
    cover property (pumpEnable && !shutterClosed);
    cover property ($rose(interfaceFault));
    cover property ($rose(powerKill));
endmodule // lsi_interlock_chk
bind lsi_interlock lsi_interlock_chk i_chk (.*);

// [bench/lsi_interlock_tb_top.sv]
`timescale 1ns/1ps
module lsi_interlock_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, laserRequest = 1'b0, internalFault = 1'b0;
    logic faultClear = 1'b0, stop1Req = 1'b0, stop2Req = 1'b0, permitReq = 1'b0;
    logic pairBreak = 1'b0, estop1, estop1N, estop2, estop2N, shutPermit, shutPermitN;
    logic lightSense, shutClosedSense, shutOpenSense, pumpEnable, shutterOpenCmd;
    logic powerKill, emissionOn, safetyStatus, shutterClosed, shutterHealthy;
    logic hazardRadiation, systemFault, interfaceFault;
    int   bad_count = 0;
    int   checked = 0;
    lsi_interlock i_dut (.*);
    lsi_far_model i_far (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic exp, input logic act);
        checked++;
        if (act !== exp) begin
            bad_count++;
            $display("ERROR %0t output %b, expected %b", $time, act, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Clear only once every cause has gone; one strobe clears the latches and leaves the trip.
    task automatic clr;
        faultClear = 1'b1;
        cyc(1);
        faultClear = 1'b0;
        cyc(4);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        complete_run();
    end
    initial begin
        cyc(2);
        chk(1'b1, shutterHealthy);
        rst = 1'b0;
        permitReq = 1'b1;
        laserRequest = 1'b1;
        cyc(20);
        chk(1'b1, emissionOn);
        chk(1'b0, shutterClosed);
        chk(1'b1, hazardRadiation);
        chk(1'b1, safetyStatus);
        stop1Req = 1'b1;
        cyc(5);
        chk(1'b0, pumpEnable);
        cyc(15);
        chk(1'b1, shutterClosed);
        chk(1'b0, emissionOn);
        chk(1'b0, hazardRadiation);
        stop1Req = 1'b0;
        cyc(10);
        chk(1'b0, pumpEnable);
        clr();
        cyc(15);
        chk(1'b1, pumpEnable);
        permitReq = 1'b0;
        cyc(5);
        chk(1'b0, shutterOpenCmd);
        cyc(15);
        chk(1'b1, shutterClosed);
        permitReq = 1'b1;
        internalFault = 1'b1;
        cyc(6);
        chk(1'b0, safetyStatus);
        chk(1'b1, systemFault);
        chk(1'b0, pumpEnable);
        internalFault = 1'b0;
        cyc(6);
        chk(1'b1, systemFault);
        clr();
        chk(1'b0, systemFault);
        chk(1'b1, safetyStatus);
        pairBreak = 1'b1;
        cyc(95);
        chk(1'b1, interfaceFault);
        pairBreak = 1'b0;
        cyc(6);
        chk(1'b1, interfaceFault);
        clr();
        chk(1'b0, interfaceFault);
        chk(1'b1, pumpEnable);
        stop2Req = 1'b1;
        cyc(6);
        chk(1'b1, powerKill);
        chk(1'b0, pumpEnable);
        stop2Req = 1'b0;
        cyc(6);
        clr();
        chk(1'b0, powerKill);
        complete_run();
    end
endmodule // lsi_interlock_tb_top
